// ### adc_sync_trigger_compare.sv
// Purpose: Three-channel ADC start trigger compare stage with AHB-Lite registers.
// Assumes: PWM counter, period, direction and enable are on hclk.
// Notes: Zero-wait slave; every answer is OKAY; unmapped reads return zero.
`timescale 1ns/1ps
module adc_sync_trigger_compare import trg_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // PWM carrier
  input wire logic [CMP_W-1:0] pwm_count,
  input wire logic [CMP_W-1:0] pwm_period,
  input wire logic count_down,
  input wire logic edge_aligned,
  input wire logic pwm_output_enable,
  // ADC start triggers
  output logic adc_start_trigger_ch1,
  output logic adc_start_trigger_ch2,
  output logic adc_start_trigger_ch3
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  logic dp_write_reg;
  logic dp_write_next;
  logic [7:0] dp_addr_reg;
  logic [7:0] dp_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hresp_reg;
  logic accept;
  logic [7:0] addr_low;

  // Register state.
  logic [CMP_W-1:0] first_reg [NUM_CH];
  logic [CMP_W-1:0] first_next [NUM_CH];
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic first_cycle_reg;
  logic first_cycle_next;
  logic en_prev_reg;
  logic en_prev_next;

  // Per-channel wiring.
  logic [NUM_CH-1:0] wr_cmp;
  logic [2:0] mode_w [NUM_CH];
  logic [NUM_CH-1:0] async_w;
  logic [CMP_W-1:0] active_w [NUM_CH];
  logic [NUM_CH-1:0] trig_w;
  logic peak;
  logic bottom;
  logic first_now;

  // Size is not checked: only whole-word transfers reach this block.
  assign addr_low = haddr[7:0];
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign peak = (pwm_count == pwm_period);
  assign bottom = (pwm_count == CNT_BOTTOM);
  // The enable edge counts as first cycle too, since the flag itself is set a clock later.
  assign first_now = first_cycle_reg | (pwm_output_enable & ~en_prev_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes land in the data phase.

  always_comb begin
    wr_cmp[0] = dp_write_reg && (dp_addr_reg == OFF_CMP_ONE);
    wr_cmp[1] = dp_write_reg && (dp_addr_reg == OFF_CMP_TWO);
    wr_cmp[2] = dp_write_reg && (dp_addr_reg == OFF_CMP_THREE);
    for (int i = 0; i < NUM_CH; i++) begin
      first_next[i] = wr_cmp[i] ? hwdata[CMP_W-1:0] : first_reg[i];
    end
    ctrl_next = ctrl_reg;
    if (dp_write_reg && (dp_addr_reg == OFF_CTRL)) begin
      ctrl_next = hwdata & CTRL_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase capture and read data.

  always_comb begin
    dp_write_next = accept && hwrite;
    dp_addr_next = accept ? addr_low : dp_addr_reg;
    hrdata_next = hrdata_reg;
    // Compare and control reads use next values so a write just before is seen at once.
    if (accept && !hwrite) begin
      if (addr_low == OFF_CMP_ONE) begin
        hrdata_next = {16'h0000, first_next[0]};
      end else if (addr_low == OFF_CMP_TWO) begin
        hrdata_next = {16'h0000, first_next[1]};
      end else if (addr_low == OFF_CMP_THREE) begin
        hrdata_next = {16'h0000, first_next[2]};
      end else if (addr_low == OFF_CTRL) begin
        hrdata_next = ctrl_next;
      end else if (addr_low == OFF_STATUS) begin
        hrdata_next = 32'h0000_0000;
        hrdata_next[STAT_FIRST_BIT] = first_cycle_reg;
        hrdata_next[STAT_EN_BIT] = en_prev_reg;
      end else if (addr_low == OFF_ACT_ONE) begin
        hrdata_next = {16'h0000, active_w[0]};
      end else if (addr_low == OFF_ACT_TWO) begin
        hrdata_next = {16'h0000, active_w[1]};
      end else if (addr_low == OFF_ACT_THREE) begin
        hrdata_next = {16'h0000, active_w[2]};
      end else begin
        hrdata_next = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First PWM cycle tracking.

  always_comb begin
    en_prev_next = pwm_output_enable;
    first_cycle_next = first_cycle_reg;
    // The cycle ends at the first carrier peak; a fresh start wins over that end.
    if (!pwm_output_enable) begin
      first_cycle_next = 1'b0;
    end else if (!en_prev_reg) begin
      first_cycle_next = 1'b1;
    end else if (peak) begin
      first_cycle_next = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      first_cycle_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        first_reg[i] <= CMP_RESET;
      end
    end else begin
      dp_write_reg <= dp_write_next;
      dp_addr_reg <= dp_addr_next;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      ctrl_reg <= ctrl_next;
      first_cycle_reg <= first_cycle_next;
      en_prev_reg <= en_prev_next;
      for (int i = 0; i < NUM_CH; i++) begin
        first_reg[i] <= first_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channels.

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign mode_w[g] = ctrl_reg[CTRL_CH_BASE + CTRL_CH_STRIDE * g +: 3];
    assign async_w[g] = ctrl_reg[CTRL_CH_BASE + CTRL_CH_STRIDE * g + CTRL_ASYNC_OFS];

    compare_buffer u_buf (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(mode_w[g]),
      .async_update_bit(async_w[g]),
      .load_block((g == 0) ? ctrl_reg[CTRL_DSEL_BIT] : 1'b0),
      .peak(peak),
      .bottom(bottom),
      .write_pulse(wr_cmp[g]),
      .first_value(first_next[g]),
      .active_compare_buffer(active_w[g])
    );

    trigger_unit u_trig (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(mode_w[g]),
      .active_value(active_w[g]),
      .pwm_count(pwm_count),
      .count_down(count_down),
      .edge_aligned(edge_aligned),
      .peak(peak),
      .bottom(bottom),
      .fire_enable(pwm_output_enable),
      .first_cycle(first_now),
      .trigger(trig_w[g])
    );
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
  assign adc_start_trigger_ch1 = trig_w[0];
  assign adc_start_trigger_ch2 = trig_w[1];
  assign adc_start_trigger_ch3 = trig_w[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks, mostly on channel one; the others share the same modules.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_trig_needs_enable: assert property (
    trig_w[0] |-> $past(pwm_output_enable))
    else $error("Trigger raised while PWM output was disabled.");

  a_trig_one_wide: assert property (
    trig_w[0] |=> !trig_w[0])
    else $error("Trigger lasted more than one clock.");

  a_read_first_buf: assert property (
    ($past(accept && !hwrite) && dp_addr_reg == OFF_CMP_ONE)
      |-> hrdata == {16'h0000, first_reg[0]})
    else $error("Compare read did not return the first buffer.");

  a_async_copy_now: assert property (
    (wr_cmp[0] && async_w[0] && !ctrl_reg[CTRL_DSEL_BIT])
      |=> active_w[0] == $past(hwdata[CMP_W-1:0]))
    else $error("Async write did not reach the active buffer.");

  a_down_mode_hold: assert property (
    (mode_w[0] == MODE_DOWN && !async_w[0] && !peak)
      |=> active_w[0] == $past(active_w[0]))
    else $error("Mode 001 reloaded away from the carrier peak.");

  a_up_mode_hold: assert property (
    (mode_w[0] == MODE_UP && !async_w[0] && !bottom)
      |=> active_w[0] == $past(active_w[0]))
    else $error("Mode 010 reloaded away from count one.");

  a_off_mode_follow: assert property (
    (mode_w[0] == MODE_OFF_LO && !ctrl_reg[CTRL_DSEL_BIT])
      |=> (active_w[0] == first_reg[0]) && !trig_w[0])
    else $error("Disabled mode did not follow or still fired.");

  a_mute_value_one: assert property (
    (first_cycle_reg && active_w[0] == CNT_BOTTOM && mode_w[0] == MODE_UPDOWN)
      |=> !trig_w[0])
    else $error("Value one fired during the first PWM cycle.");

  a_peak_fires: assert property (
    (mode_w[0] == MODE_PEAK && pwm_output_enable && peak && !$past(peak)
      && $past(mode_w[0]) == MODE_PEAK && $past(pwm_output_enable))
      |=> trig_w[0])
    else $error("Peak mode missed the carrier peak.");

  a_zero_wait_ok: assert property (
    accept |=> hreadyout && !hresp)
    else $error("Slave did not answer with zero wait and OKAY.");

  a_mute_enable_edge: assert property (
    (pwm_output_enable && !en_prev_reg && active_w[0] == CNT_BOTTOM
      && mode_w[0] == MODE_UPDOWN) |=> !trig_w[0])
    else $error("Value one fired in the clock that enabled the PWM.");

  a_updown_hold: assert property (
    (mode_w[0] == MODE_UPDOWN && !async_w[0] && !peak && !bottom)
      |=> active_w[0] == $past(active_w[0]))
    else $error("Mode 011 reloaded away from count one and the peak.");

  a_edge_no_bottom: assert property (
    (mode_w[0] == MODE_BOTTOM && edge_aligned && !peak) |=> !trig_w[0])
    else $error("Edge-aligned bottom mode fired away from the peak.");

  a_match_fires: assert property (
    (mode_w[1] == MODE_UPDOWN && $past(mode_w[1]) == MODE_UPDOWN && pwm_output_enable
      && !first_now && pwm_count == active_w[1] && !$past(pwm_count == active_w[1]))
      |=> trig_w[1])
    else $error("Channel two missed a compare match.");

  a_peak_follows: assert property (
    mode_w[1] == MODE_PEAK |=> active_w[1] == first_reg[1])
    else $error("Peak mode did not reload continuously.");

  a_ch2_one_wide: assert property (
    trig_w[1] |=> !trig_w[1])
    else $error("Channel two trigger lasted more than one clock.");

  a_ch3_off_follow: assert property (
    mode_w[2] == MODE_OFF_HI |=> (active_w[2] == first_reg[2]) && !trig_w[2])
    else $error("Mode 111 did not follow or still fired.");

  a_ch3_needs_enable: assert property (
    trig_w[2] |-> $past(pwm_output_enable))
    else $error("Channel three fired while PWM output was disabled.");

  a_ch3_one_wide: assert property (
    trig_w[2] |=> !trig_w[2])
    else $error("Channel three trigger lasted more than one clock.");

endmodule : adc_sync_trigger_compare

// ### compare_buffer.sv
// Purpose: Second (active) stage of one double-buffered compare register.
// Assumes: first_value already includes a write landing this cycle.
// Notes: The active value is what the matcher compares against.
`timescale 1ns/1ps
module compare_buffer import trg_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Load control
  input wire logic [2:0] mode,
  input wire logic async_update_bit,
  input wire logic load_block,
  input wire logic peak,
  input wire logic bottom,
  input wire logic write_pulse,
  // Data
  input wire logic [CMP_W-1:0] first_value,
  output logic [CMP_W-1:0] active_compare_buffer
);

  logic [CMP_W-1:0] active_reg;
  logic [CMP_W-1:0] active_next;
  logic load_now;

  always_comb begin
    case (mode)
      MODE_DOWN: begin
        load_now = peak;
      end
      MODE_UP: begin
        load_now = bottom;
      end
      MODE_UPDOWN: begin
        load_now = peak | bottom;
      end
      default: begin
        // Follow continuously, also for the carrier-point modes.
        load_now = 1'b1;
      end
    endcase
    active_next = active_reg;
    if (!load_block && ((async_update_bit && write_pulse) || load_now)) begin
      active_next = first_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_reg <= CMP_RESET;
    end else begin
      active_reg <= active_next;
    end
  end

  assign active_compare_buffer = active_reg;

endmodule : compare_buffer

// ### pwm_carrier_model.sv
// Purpose: Behavioural PWM carrier counter that feeds the compare stage.
// Assumes: The count runs from one to the period, as a triangle or a sawtooth.
// Notes: The count parks at one while stopped, as a real carrier does.
`timescale 1ns/1ps
module pwm_carrier_model import trg_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Setup
  input wire logic run,
  input wire logic saw,
  input wire logic [CMP_W-1:0] period,
  // Carrier
  output logic [CMP_W-1:0] count,
  output logic down
);
  logic [CMP_W-1:0] count_next;
  logic down_next;
  logic run_reg;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    count_next = count;
    down_next = down;
    if (!run_reg) begin
      count_next = CNT_BOTTOM;
      down_next = 1'b0;
    end else if (saw) begin
      count_next = (count >= period) ? CNT_BOTTOM : count + 16'h0001;
      down_next = 1'b0;
    end else if (!down) begin
      count_next = count + 16'h0001;
      down_next = (count_next >= period);
    end else begin
      count_next = count - 16'h0001;
      down_next = (count_next > CNT_BOTTOM);
    end
  end
  // The start is delayed one clock so the count sits at one when output turns on.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= CNT_BOTTOM;
      down <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      count <= count_next;
      down <= down_next;
      run_reg <= run;
    end
  end
endmodule : pwm_carrier_model

// ### testbench.sv
// Purpose: Self-checking bench for the ADC start trigger compare stage.
// Assumes: Zero-wait slave; the carrier model runs on the same clock.
// Notes: Trigger counts are taken over whole carrier periods, except the mute count over the first up-count.
`timescale 1ns/1ps
module testbench import trg_pkg::*; ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic en = 1'b0;
  logic saw = 1'b0;
  logic spin = 1'b0;
  logic [15:0] per = 16'h0018;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] cnt;
  logic dn;
  logic [3:1] trg;
  logic [3:1] ptrg = 3'h0;
  logic [15:0] prv_cnt = 16'h0;
  logic prv_dn = 1'b0;
  logic [2:0] cmode [3:1] = '{3'h0, 3'h0, 3'h0};
  logic [15:0] ccmp [3:1];
  logic [2:0] bm [9] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h0, 3'h7, 3'h4, 3'h5, 3'h6};
  logic ba [9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  int tcount [3:1];
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic mon = 1'b0;
  logic cnt_on = 1'b0;
  logic [31:0] seed = 32'h0000_004b;
  ////////////////////////////////////////////////////////////////////////////
  adc_sync_trigger_compare u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pwm_count(cnt),
    .pwm_period(per), .count_down(dn), .edge_aligned(saw), .pwm_output_enable(en),
    .adc_start_trigger_ch1(trg[1]), .adc_start_trigger_ch2(trg[2]),
    .adc_start_trigger_ch3(trg[3]));
  pwm_carrier_model u_carrier (.hclk(hclk), .hresetn(hresetn), .run(en | spin),
    .saw(saw), .period(per), .count(cnt), .down(dn));
  initial begin
    forever #2 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_count(input logic [2:0] m, input logic s);
    if (m == 3'h0 || m == 3'h7) return 0;
    if ((m == 3'h3 || m == 3'h6) && !s) return 2;
    return 1;
  endfunction : exp_count
  function automatic logic pos_ok(input logic [2:0] m, input logic [15:0] c);
    logic pk;
    logic bt;
    pk = (prv_cnt == per);
    bt = (prv_cnt == CNT_BOTTOM) && !saw;
    case (m)
      3'h1: return prv_cnt == c && (saw || prv_dn);
      3'h2: return prv_cnt == c && !prv_dn;
      3'h3: return prv_cnt == c;
      3'h4: return pk;
      3'h5: return saw ? pk : bt;
      3'h6: return pk || bt;
      default: return 1'b0;
    endcase
  endfunction : pos_ok
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(n, q, e);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : rdc
  // source select kept at bus mode.
  task automatic set_ctrl(input logic a1);
    logic [31:0] c;
    c = 32'h0;
    for (int n = 1; n <= 3; n++) c[CTRL_CH_BASE + CTRL_CH_STRIDE * (n - 1) +: 3] = cmode[n];
    c[CTRL_CH_BASE + CTRL_ASYNC_OFS] = a1;
    wr(OFF_CTRL, c);
  endtask : set_ctrl
  // values stay in range and go in one word access.
  task automatic load(input logic [15:0] p, input logic s, input logic a1);
    per <= p;
    saw <= s;
    for (int n = 1; n <= 3; n++) wr(OFF_CMP_ONE + 8'(4 * (n - 1)), {16'h0, ccmp[n]});
    set_ctrl(a1);
  endtask : load
  task automatic wait_at(input logic [15:0] v, input logic d);
    @(posedge hclk);
    while (cnt !== v || dn !== d) @(posedge hclk);
  endtask : wait_at
  task automatic window(input int len);
    for (int n = 1; n <= 3; n++) tcount[n] = 0;
    cnt_on <= 1'b1;
    repeat (len) @(posedge hclk);
    cnt_on <= 1'b0;
    @(posedge hclk);
  endtask : window
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    for (int n = 1; n <= 3; n++) begin
      if (trg[n] === 1'b1 && cnt_on) tcount[n]++;
      if (trg[n] === 1'b1 && mon) begin
        check("trg_pos", {31'h0, pos_ok(cmode[n], ccmp[n])}, 32'h1);
        check("trg_width", {31'h0, ptrg[n]}, 32'h0);
      end
    end
    ptrg = trg;
    prv_cnt = cnt;
    prv_dn = dn;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] p;
    logic nw;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      rdc("cmp_reset", OFF_CMP_ONE + 8'(4 * n), 32'h0);
      r = rnd();
      wr(OFF_CMP_ONE + 8'(4 * n), {16'hffff, 12'h0, r[3:0]} + 32'h2);
      rdc("cmp_read", OFF_CMP_ONE + 8'(4 * n), {28'h0, r[3:0]} + 32'h2);
    end
    rdc("unmapped", 8'h40, 32'h0);
    en <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      cmode[1] = 3'h0;
      set_ctrl(1'b0);
      wr(OFF_CMP_ONE, 32'h0000_0005);
      cmode[1] = bm[k];
      set_ctrl(ba[k]);
      wait_at(16'h000c, 1'b0);
      wr(OFF_CMP_ONE, 32'h0000_0009);
      rdc("cmp_first", OFF_CMP_ONE, 32'h0000_0009);
      nw = ba[k] || bm[k] == 3'h0 || bm[k] >= 3'h4;
      rdc("act_now", OFF_ACT_ONE, nw ? 32'h9 : 32'h5);
      wait_at(per, 1'b1);
      nw = nw || bm[k] == 3'h1 || bm[k] == 3'h3;
      rdc("act_peak", OFF_ACT_ONE, nw ? 32'h9 : 32'h5);
      wait_at(CNT_BOTTOM, 1'b0);
      rdc("act_bottom", OFF_ACT_ONE, 32'h9);
    end
    for (int i = 0; i < 8; i++) begin
      en <= 1'b0;
      r = rnd();
      p = 16'h0010 + {11'h0, r[4:0]};
      for (int n = 1; n <= 3; n++) begin
        r = rnd();
        cmode[n] = 3'(i + 3 * n);
        ccmp[n] = 16'h0002 + r[15:0] % (p - 16'h0002);
      end
      if (i == 2) ccmp[1] = 16'h0002;
      if (i == 2) ccmp[2] = p - 16'h0001;
      load(p, r[31], 1'b0);
      en <= 1'b1;
      repeat (4 * p) @(posedge hclk);
      mon = 1'b1;
      window(r[31] ? 3 * p : 6 * p - 6);
      mon = 1'b0;
      for (int n = 1; n <= 3; n++)
        check("trg_count", 32'(tcount[n]), 32'(3 * exp_count(cmode[n], r[31])));
    end
    en <= 1'b0;
    spin <= 1'b1;
    cmode = '{3'h3, 3'h6, 3'h5};
    ccmp = '{16'h0005, 16'h000a, 16'h0013};
    load(16'h0014, 1'b0, 1'b0);
    window(76);
    for (int n = 1; n <= 3; n++) check("trg_off", 32'(tcount[n]), 32'h0);
    spin <= 1'b0;
    cmode = '{3'h3, 3'h3, 3'h3};
    ccmp = '{16'h0001, 16'h0001, 16'h0001};
    load(16'h0014, 1'b0, 1'b0);
    repeat (4) @(posedge hclk);
    en <= 1'b1;
    mon = 1'b1;
    window(20);
    for (int n = 1; n <= 3; n++) check("trg_mute", 32'(tcount[n]), 32'h0);
    window(76);
    for (int n = 1; n <= 3; n++) check("trg_after", 32'(tcount[n]), 32'h2);
    summarize();
  end
endmodule : testbench

// ### trg_pkg.sv
// Purpose: Shared constants for the ADC start trigger compare stage.
// Assumes: One clock, AHB-Lite register access, 16-bit PWM carrier.
// Notes: Offsets are byte addresses of aligned 32-bit words.
//
// How it works
// - A channel raises its start trigger when the PWM count equals its active compare value.
// - Reading a compare register returns the bus-side first buffer, upper bits zero.
// - A compare value of one gives no trigger in the first PWM cycle after enable.
// - Writes land in the first buffer and move to the active buffer at a mode-chosen moment.
// - With the async bit set, a written value goes to the active buffer at once.
// - Modes 000 and 111 disable the trigger and the active buffer follows continuously.
// - Mode 001 fires on a down-count match and reloads only at the carrier peak.
// - Mode 010 fires on an up-count match and reloads only when the count is one.
// - Mode 011 fires on both matches and reloads at count one or at the peak.
// - Modes 100, 101, 110 fire at peak, bottom or both (all at the peak when edge-aligned), reloading continuously.
// - No channel triggers while the PWM output enable is low.
// - In edge-aligned mode a down-count selection fires on the up-count match.
package trg_pkg;

  localparam int CMP_W = 16;
  localparam int NUM_CH = 3;

  localparam logic [7:0] OFF_CMP_ONE = 8'h00;
  localparam logic [7:0] OFF_CMP_TWO = 8'h04;
  localparam logic [7:0] OFF_CMP_THREE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_ACT_ONE = 8'h14;
  localparam logic [7:0] OFF_ACT_TWO = 8'h18;
  localparam logic [7:0] OFF_ACT_THREE = 8'h1c;

  // Control layout: channel n (1..3) mode at 4n+2..4n, async bit at 4n+3.
  localparam int CTRL_CH_BASE = 4;
  localparam int CTRL_CH_STRIDE = 4;
  localparam int CTRL_ASYNC_OFS = 3;
  localparam int CTRL_DSEL_BIT = 16;
  localparam logic [31:0] CTRL_WMASK = 32'h0001_fff0;

  localparam int STAT_FIRST_BIT = 0;
  localparam int STAT_EN_BIT = 1;

  localparam logic [CMP_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [CMP_W-1:0] CNT_BOTTOM = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    MODE_OFF_LO = 3'h0,
    MODE_DOWN = 3'h1,
    MODE_UP = 3'h2,
    MODE_UPDOWN = 3'h3,
    MODE_PEAK = 3'h4,
    MODE_BOTTOM = 3'h5,
    MODE_PEAKBOT = 3'h6,
    MODE_OFF_HI = 3'h7
  } trig_mode_e;

endpackage : trg_pkg

// ### trigger_unit.sv
// Purpose: Match qualification and one-clock start pulse for one channel.
// Assumes: PWM count, direction and enable come from logic on hclk.
// Notes: The pulse marks the first cycle a qualifying condition holds.
`timescale 1ns/1ps
module trigger_unit import trg_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Channel setup
  input wire logic [2:0] mode,
  input wire logic [CMP_W-1:0] active_value,
  // Carrier state
  input wire logic [CMP_W-1:0] pwm_count,
  input wire logic count_down,
  input wire logic edge_aligned,
  input wire logic peak,
  input wire logic bottom,
  input wire logic fire_enable,
  input wire logic first_cycle,
  // Trigger
  output logic trigger
);

  logic qual_reg;
  logic qual_next;
  logic trig_reg;
  logic trig_next;
  logic match;
  logic down_eff;
  logic hit;

  always_comb begin
    // Edge-aligned counting has no down slope.
    down_eff = count_down & ~edge_aligned;
    match = (pwm_count == active_value);
    case (mode)
      MODE_DOWN: begin
        hit = match & (down_eff | edge_aligned);
      end
      MODE_UP: begin
        hit = match & ~down_eff;
      end
      MODE_UPDOWN: begin
        hit = match;
      end
      MODE_PEAK: begin
        hit = peak;
      end
      MODE_BOTTOM: begin
        hit = edge_aligned ? peak : bottom;
      end
      MODE_PEAKBOT: begin
        hit = edge_aligned ? peak : (peak | bottom);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // Value one muted in first cycle.
    if (first_cycle && active_value == CNT_BOTTOM && mode != MODE_PEAK &&
        mode != MODE_BOTTOM && mode != MODE_PEAKBOT) begin
      hit = 1'b0;
    end
    qual_next = hit & fire_enable;
    trig_next = qual_next & ~qual_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      qual_reg <= qual_next;
      trig_reg <= trig_next;
    end
  end

  assign trigger = trig_reg;

endmodule : trigger_unit
